/* hdl/psw_map.svh */
// status word bit positions, fixed values and fault vectors
// assumes inclusion by bare name from every design file that needs it
`ifndef PSW_MAP_SVH
`define PSW_MAP_SVH

`define PSW_CARRY 0
`define PSW_FIXED_ONE 1
`define PSW_PARITY 2
`define PSW_HALF 4
`define PSW_ZERO 6
`define PSW_SIGN 7
`define PSW_STEP 8
`define PSW_INT_EN 9
`define PSW_DIR 10
`define PSW_OVF 11
`define PSW_IOLVL_LO 12
`define PSW_IOLVL_HI 13
`define PSW_NEST 14
`define PSW_RESUME 16
`define PSW_LEGACY 17
`define PSW_ALIGN_CHK 18

`define PSW_DEFINED_MASK 32'h0007_7fd5
`define PSW_RESET 32'h0000_0002
`define NIO_RESET 32'h0000_0000

`define VEC_DEBUG 8'h01
`define VEC_GEN_PROT 8'h0d
`define VEC_ALIGN 8'h11
`define ALIGN_ERR_CODE 32'h0000_0000

`define RING_KERNEL 2'h0
`define RING_USER 2'h3

`endif

/* hdl/psw_pkg.sv */
// types shared by the status word logic and its flag calculator
// assumes nothing beyond a SystemVerilog compiler
package psw_pkg;
  typedef enum logic [1:0] {SZ8, SZ16, SZ32} op_size_t;
  typedef enum logic [1:0] {LD_NONE, LD_POP, LD_RETURN, LD_TASK} load_kind_t;
  typedef enum logic [1:0] {AL1, AL2, AL4, AL8} align_t;
endpackage

/* hdl/flag_calc.sv */
// add/subtract with result flags for 8-, 16- and 32-bit operand sizes
// assumes operands are zero-extended to 32 bits by the caller
`timescale 1ns/1ps
module flag_calc import psw_pkg::*; #(
  parameter int W = 32
) (
  // operation
  input wire logic [W-1:0] i_a,
  input wire logic [W-1:0] i_b,
  input wire logic i_sub,
  input wire op_size_t i_size,
  // result and flags
  output logic [W-1:0] o_result,
  output logic o_carry,
  output logic o_parity,
  output logic o_half,
  output logic o_zero,
  output logic o_sign,
  output logic o_ovf
);
  logic [W-1:0] ext;
  logic [W:0] full;
  logic [W:0] carry;
  logic c_in_msb;
  logic c_out_msb;

  assign ext = i_sub ? ~i_b : i_b;
  assign full = {1'b0, i_a} + {1'b0, ext} + {{W{1'b0}}, i_sub};
  // carry[i] is the carry into bit i
  assign carry = {full[W], i_a ^ ext ^ full[W-1:0]};

  always_comb begin
    o_result = full[W-1:0];
    c_in_msb = carry[W-1];
    c_out_msb = carry[W];
    unique case (i_size)
      SZ8: begin
        o_result = {{(W-8){1'b0}}, full[7:0]};
        c_in_msb = carry[7];
        c_out_msb = carry[8];
      end
      SZ16: begin
        o_result = {{(W-16){1'b0}}, full[15:0]};
        c_in_msb = carry[15];
        c_out_msb = carry[16];
      end
      SZ32: begin
        o_result = full[W-1:0];
        c_in_msb = carry[W-1];
        c_out_msb = carry[W];
      end
      default: begin
        o_result = full[W-1:0];
        c_in_msb = carry[W-1];
        c_out_msb = carry[W];
      end
    endcase
  end

  assign o_carry = c_out_msb ^ i_sub;
  assign o_parity = ~^o_result[7:0];
  assign o_half = carry[4] ^ i_sub;
  assign o_zero = (o_result == '0);
  assign o_sign = (i_size == SZ8) ? o_result[7] : (i_size == SZ16) ? o_result[15] : o_result[W-1];
  assign o_ovf = c_in_msb ^ c_out_msb;
endmodule // flag_calc

/* hdl/status_flags_and_align_check.sv */
// status word, next instruction offset and alignment fault logic of the core
// assumes the execution unit, exception logic and privilege state share i_sys_clk
`timescale 1ns/1ps
`include "psw_map.svh"
module status_flags_and_align_check import psw_pkg::*; (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // instruction retirement
  input wire logic i_retire,
  input wire logic [31:0] i_next_offset,
  // arithmetic
  input wire logic i_alu_valid,
  input wire logic i_alu_sub,
  input wire op_size_t i_alu_size,
  input wire logic [31:0] i_alu_a,
  input wire logic [31:0] i_alu_b,
  // status word image load
  input wire load_kind_t i_load_kind,
  input wire logic [31:0] i_load_image,
  // privilege state
  input wire logic [1:0] i_current_ring,
  input wire logic i_protected_mode,
  // memory reference check
  input wire logic i_mem_req,
  input wire logic [31:0] i_mem_addr,
  input wire align_t i_mem_align,
  input wire logic i_sys_ref,
  input wire logic i_split,
  input wire logic [31:0] i_eff_addr,
  // instruction class checks
  input wire logic i_io_instr,
  input wire logic i_priv_opcode,
  input wire logic i_bkpt_match,
  // external interrupt pin
  input wire logic i_maskable_interrupt_pin,
  // register views
  output logic [31:0] o_next_instr_offset,
  output logic [15:0] o_short_instr_offset,
  output logic [31:0] o_status_word,
  output logic [31:0] o_push_image,
  output logic [31:0] o_event_image,
  output logic [31:0] o_alu_result,
  // mode controls
  output logic o_legacy_segments,
  output logic o_string_decrement,
  output logic o_nested_return,
  output logic o_io_bitmap_check,
  output logic o_irq_recognised,
  // faults and traps
  output logic o_align_fault,
  output logic o_gp_fault,
  output logic o_step_trap,
  output logic o_debug_fault,
  output logic [7:0] o_align_vector,
  output logic [31:0] o_align_err_code,
  output logic [7:0] o_gp_vector,
  output logic [7:0] o_debug_vector
);
  logic carry_f, parity_f, half_f, zero_f, sign_f, ovf_f;
  logic step_f, int_en, dir_f, nest_f, resume_f, legacy_f, align_chk;
  logic [1:0] io_level;
  logic [31:0] calc_res;
  logic c_carry, c_parity, c_half, c_zero, c_sign, c_ovf;
  logic pin_s1, pin_s2, pin_s3, pin_level;
  logic loading, ring0, io_ok, misaligned;
  logic [31:0] chk_addr;

  flag_calc #(.W(32)) flag_calc_inst (
    .i_a(i_alu_a),
    .i_b(i_alu_b),
    .i_sub(i_alu_sub),
    .i_size(i_alu_size),
    .o_result(calc_res),
    .o_carry(c_carry),
    .o_parity(c_parity),
    .o_half(c_half),
    .o_zero(c_zero),
    .o_sign(c_sign),
    .o_ovf(c_ovf)
  );

  assign loading = (i_load_kind != LD_NONE);
  assign ring0 = (i_current_ring == `RING_KERNEL);
  assign io_ok = (i_current_ring <= io_level);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_next_instr_offset <= `NIO_RESET;
    end else if (i_ce && i_retire) begin
      o_next_instr_offset <= i_next_offset;
    end
  end
  assign o_short_instr_offset = o_next_instr_offset[15:0];

  // arithmetic flags: an image load wins over an ALU update
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {carry_f, parity_f, half_f, zero_f, sign_f, ovf_f} <= 6'h00;
      o_alu_result <= 32'h0000_0000;
    end else if (i_ce) begin
      if (loading) begin
        carry_f <= i_load_image[`PSW_CARRY];
        parity_f <= i_load_image[`PSW_PARITY];
        half_f <= i_load_image[`PSW_HALF];
        zero_f <= i_load_image[`PSW_ZERO];
        sign_f <= i_load_image[`PSW_SIGN];
        ovf_f <= i_load_image[`PSW_OVF];
      end else if (i_alu_valid) begin
        {carry_f, parity_f, half_f, zero_f, sign_f, ovf_f} <=
          {c_carry, c_parity, c_half, c_zero, c_sign, c_ovf};
      end
      if (i_alu_valid) begin
        o_alu_result <= calc_res;
      end
    end
  end

  // plain control bits reloaded by any image load
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {step_f, dir_f, align_chk, nest_f} <= 4'h0;
    end else if (i_ce && loading) begin
      step_f <= i_load_image[`PSW_STEP];
      dir_f <= i_load_image[`PSW_DIR];
      align_chk <= i_load_image[`PSW_ALIGN_CHK];
      nest_f <= i_load_image[`PSW_NEST];
    end
  end

  // interrupt enable change guarded by io level, except on a task load
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_en <= 1'b0;
    end else if (i_ce && (i_load_kind == LD_TASK || (loading && io_ok))) begin
      int_en <= i_load_image[`PSW_INT_EN];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      io_level <= 2'h0;
    end else if (i_ce && (i_load_kind == LD_TASK || (loading && ring0))) begin
      io_level <= i_load_image[`PSW_IOLVL_HI:`PSW_IOLVL_LO];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      legacy_f <= 1'b0;
    end else if (i_ce) begin
      if (i_load_kind == LD_TASK) begin
        legacy_f <= i_load_image[`PSW_LEGACY];
      end else if (i_load_kind == LD_RETURN && ring0 && i_protected_mode) begin
        legacy_f <= i_load_image[`PSW_LEGACY];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      resume_f <= 1'b0;
    end else if (i_ce) begin
      if (loading) begin
        resume_f <= i_load_image[`PSW_RESUME];
      end else if (i_retire) begin
        resume_f <= 1'b0;
      end
    end
  end

  assign o_status_word = `PSW_RESET | ({13'h0000, align_chk, legacy_f, resume_f, 1'b0, nest_f,
    io_level, ovf_f, dir_f, int_en, step_f, sign_f, zero_f, 1'b0, half_f, 1'b0, parity_f, 1'b0,
    carry_f} & `PSW_DEFINED_MASK);
  // push shows legacy mode as zero
  assign o_push_image = o_status_word & ~(32'h0000_0001 << `PSW_LEGACY);
  assign o_event_image = o_status_word;

  assign o_legacy_segments = legacy_f & i_protected_mode;
  assign o_string_decrement = dir_f;
  assign o_nested_return = nest_f;
  assign o_io_bitmap_check = i_io_instr & ~io_ok;

  // pin synchroniser; level moves when stages two and three agree
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {pin_s1, pin_s2, pin_s3, pin_level} <= 4'h0;
    end else if (i_ce) begin
      pin_s1 <= i_maskable_interrupt_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
    end
  end
  assign o_irq_recognised = pin_level & int_en;

  // split accesses judged on effective address
  assign chk_addr = i_split ? i_eff_addr : i_mem_addr;

  always_comb begin
    unique case (i_mem_align)
      AL1: misaligned = 1'b0;
      AL2: misaligned = chk_addr[0];
      AL4: misaligned = |chk_addr[1:0];
      AL8: misaligned = |chk_addr[2:0];
      default: misaligned = 1'b0;
    endcase
  end

  // faults and traps, registered from their conditions on each enabled cycle
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {o_align_fault, o_gp_fault, o_step_trap, o_debug_fault} <= 4'h0;
    end else if (i_ce) begin
      o_align_fault <= i_mem_req & align_chk & misaligned & ~i_sys_ref &
                       (i_current_ring == `RING_USER);
      o_gp_fault <= i_priv_opcode & legacy_f & i_protected_mode;
      o_step_trap <= i_retire & step_f;
      o_debug_fault <= i_bkpt_match & ~resume_f;
    end
  end

  assign o_align_vector = `VEC_ALIGN;
  assign o_align_err_code = `ALIGN_ERR_CODE;
  assign o_gp_vector = `VEC_GEN_PROT;
  assign o_debug_vector = `VEC_DEBUG;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  a_align_vector: assert property (o_align_fault |-> o_align_vector == 8'h11 &&
    o_align_err_code == 32'h0) else $error("alignment fault vector or code wrong");
  a_align_gate: assert property (o_align_fault |-> $past(align_chk) &&
    $past(i_current_ring) == 2'h3 && !$past(i_sys_ref)) else $error("fault outside ring 3");
  a_align_enable: assert property (i_ce && !align_chk |=> !o_align_fault)
    else $error("fault with check disabled");
  a_saved_fixed: assert property (o_push_image[1] && !o_push_image[3] &&
    !o_push_image[5] && !o_push_image[15] && o_push_image[31:19] == 13'h0)
    else $error("saved image fixed bits wrong");
  a_pop_vm: assert property (i_ce && i_load_kind == LD_POP |=> $stable(legacy_f))
    else $error("flag pop changed legacy mode");
  a_io_privilege_level_guard: assert property (i_ce && (i_load_kind == LD_POP ||
    i_load_kind == LD_RETURN) && !ring0 |=> $stable(io_level)) else $error("io level changed");
  a_task_iolvl: assert property (i_ce && i_load_kind == LD_TASK |=>
    io_level == $past(i_load_image[13:12])) else $error("task load kept io level");
  a_rf_clear: assert property (i_ce && i_retire && !loading |=> !resume_f)
    else $error("resume bit not cleared");
  a_debug_mask: assert property (i_ce && resume_f |=> !o_debug_fault)
    else $error("debug fault while resume set");
  a_maskable_interrupt_pin_gate: assert property (o_irq_recognised |-> int_en)
    else $error("interrupt recognised while disabled");
  a_zero_parity: assert property (i_ce && i_alu_valid && !loading |=>
    zero_f == (o_alu_result == 32'h0) && parity_f == ~^o_alu_result[7:0])
    else $error("zero or parity");
  a_io_direct: assert property (i_io_instr && i_current_ring <= io_level |->
    !o_io_bitmap_check) else $error("bitmap check within io level");
  a_gp_legacy: assert property (i_ce && i_priv_opcode && legacy_f && i_protected_mode |=>
    o_gp_fault) else $error("privileged opcode not faulted");
  a_step_trap: assert property (i_ce && i_retire && step_f |=> o_step_trap)
    else $error("single step trap missing");
  a_step_quiet: assert property (i_ce && !i_retire |=> !o_step_trap)
    else $error("step trap without retirement");
endmodule // status_flags_and_align_check

/* verification/status_flags_and_align_check_tb.sv */
// self-checking bench for the status word, offset and alignment fault block
// assumes the block's design files are compiled first; bench drives all ports
`timescale 1ns/1ps
`include "psw_map.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module status_flags_and_align_check_tb import psw_pkg::*;;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_ce = 1'b1;
  logic i_retire = 1'b0;
  logic [31:0] i_next_offset = 32'h0;
  logic i_alu_valid = 1'b0;
  logic i_alu_sub = 1'b0;
  op_size_t i_alu_size = SZ8;
  logic [31:0] i_alu_a = 32'h0;
  logic [31:0] i_alu_b = 32'h0;
  load_kind_t i_load_kind = LD_NONE;
  logic [31:0] i_load_image = 32'h0;
  logic [1:0] i_current_ring = 2'h3;
  logic i_protected_mode = 1'b1;
  logic i_mem_req = 1'b0;
  logic [31:0] i_mem_addr = 32'h0;
  align_t i_mem_align = AL1;
  logic i_sys_ref = 1'b0;
  logic i_split = 1'b0;
  logic [31:0] i_eff_addr = 32'h0;
  logic i_io_instr = 1'b0;
  logic i_priv_opcode = 1'b0;
  logic i_bkpt_match = 1'b0;
  logic i_maskable_interrupt_pin = 1'b0;
  logic [31:0] o_next_instr_offset, o_status_word, o_push_image, o_event_image, o_alu_result;
  logic [15:0] o_short_instr_offset;
  logic o_legacy_segments, o_string_decrement, o_nested_return, o_io_bitmap_check;
  logic o_irq_recognised, o_align_fault, o_gp_fault, o_step_trap, o_debug_fault;
  logic [7:0] o_align_vector, o_gp_vector, o_debug_vector;
  logic [31:0] o_align_err_code;
  int n_mismatch = 0;
  int check_count = 0;

  status_flags_and_align_check status_flags_and_align_check_inst (.*);

  always #10 i_sys_clk = ~i_sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask

  task automatic alu(input logic sub, input op_size_t sz, input logic [31:0] a, b);
    i_alu_valid = 1'b1;
    i_alu_sub = sub;
    i_alu_size = sz;
    i_alu_a = a;
    i_alu_b = b;
    step();
  endtask

  task automatic load(input load_kind_t k, input logic [1:0] ring, input logic [31:0] img);
    i_current_ring = ring;
    i_load_kind = k;
    i_load_image = img;
    step();
    i_load_kind = LD_NONE;
  endtask

  task automatic mem(input align_t al, input logic [31:0] a, input logic sp, sys, exp);
    i_mem_req = 1'b1;
    i_mem_align = al;
    i_mem_addr = a;
    i_split = sp;
    i_eff_addr = 32'h0;
    i_sys_ref = sys;
    step();
    `CHK(o_align_fault, exp);
  endtask

  task automatic t_alu();
    alu(1'b0, SZ8, 32'hff, 32'h1);
    `CHK(o_alu_result, 32'h0);
    `CHK(o_status_word, 32'h57);
    alu(1'b1, SZ16, 32'h0, 32'h1);
    `CHK(o_alu_result, 32'hffff);
    `CHK(o_status_word, 32'h97);
    alu(1'b0, SZ32, 32'h7fff_ffff, 32'h1);
    `CHK(o_status_word, 32'h896);
    i_ce = 1'b0;
    i_alu_a = 32'h0;
    step();
    `CHK(o_status_word, 32'h896);
    `CHK(o_alu_result, 32'h8000_0000);
    i_alu_valid = 1'b0;
    i_ce = 1'b1;
    $display("test alu done");
  endtask

  task automatic t_pop_user();
    load(LD_POP, 2'h3, 32'hffff_ffff);
    `CHK(o_status_word, 32'h0005_4dd7);
    `CHK(o_push_image, 32'h0005_4dd7);
    `CHK({o_string_decrement, o_nested_return}, 2'h3);
    i_io_instr = 1'b1;
    #1 `CHK(o_io_bitmap_check, 1'b1);
    i_retire = 1'b1;
    i_next_offset = 32'h1234_5679;
    i_bkpt_match = 1'b1;
    step();
    i_retire = 1'b0;
    i_bkpt_match = 1'b0;
    `CHK(o_debug_fault, 1'b0);
    i_io_instr = 1'b0;
    `CHK(o_step_trap, 1'b1);
    `CHK(o_status_word, 32'h0004_4dd7);
    `CHK(o_next_instr_offset, 32'h1234_5679);
    `CHK(o_short_instr_offset, 16'h5679);
    step();
    `CHK(o_step_trap, 1'b0);
    $display("test pop user done");
  endtask

  task automatic t_align();
    align_t al[6] = '{AL2, AL2, AL4, AL4, AL8, AL8};
    logic [31:0] ad[6] = '{32'h1, 32'h2, 32'h2, 32'h4, 32'h4, 32'h8};
    for (int k = 0; k < 6; k++) begin
      mem(al[k], ad[k], 1'b0, 1'b0, (k % 2) == 0);
    end
    mem(AL4, 32'h6, 1'b1, 1'b0, 1'b0);
    mem(AL4, 32'h6, 1'b0, 1'b1, 1'b0);
    `CHK({o_align_vector, o_align_err_code}, {8'h11, 32'h0});
    i_current_ring = 2'h2;
    mem(AL4, 32'h6, 1'b0, 1'b0, 1'b0);
    i_mem_req = 1'b0;
    $display("test align done");
  endtask

  task automatic t_task_and_interrupt_return_instr();
    int n;
    load(LD_TASK, 2'h3, 32'h0002_3200);
    `CHK(o_status_word, 32'h0002_3202);
    `CHK(o_push_image, 32'h0000_3202);
    `CHK(o_event_image, 32'h0002_3202);
    `CHK(o_legacy_segments, 1'b1);
    i_io_instr = 1'b1;
    #1 `CHK(o_io_bitmap_check, 1'b0);
    i_io_instr = 1'b0;
    i_priv_opcode = 1'b1;
    i_bkpt_match = 1'b1;
    step();
    i_priv_opcode = 1'b0;
    i_bkpt_match = 1'b0;
    `CHK({o_gp_fault, o_gp_vector}, {1'b1, 8'h0d});
    `CHK({o_debug_fault, o_debug_vector}, {1'b1, 8'h01});
    i_maskable_interrupt_pin = 1'b1;
    n = 0;
    while (o_irq_recognised !== 1'b1 && n < 10) begin
      step();
      n++;
    end
    if (n == 10) begin
      n_mismatch++;
      test_done();
    end
    load(LD_POP, 2'h3, 32'h0);
    `CHK(o_status_word, 32'h0002_3002);
    `CHK(o_irq_recognised, 1'b0);
    mem(AL2, 32'h1, 1'b0, 1'b0, 1'b0);
    i_mem_req = 1'b0;
    load(LD_RETURN, 2'h0, 32'h0000_1000);
    `CHK(o_status_word, 32'h0000_1002);
    `CHK(o_legacy_segments, 1'b0);
    $display("test task and interrupt_return_instr done");
  endtask

  initial begin
    repeat (4) @(negedge i_sys_clk);
    `CHK(o_status_word, 32'h2);
    `CHK(o_next_instr_offset, 32'h0);
    i_arst_n = 1'b1;
    step();
    t_alu();
    t_pop_user();
    t_align();
    t_task_and_interrupt_return_instr();
    test_done();
  end
endmodule // status_flags_and_align_check_tb
